// ==== amf_front_model.sv ====
// amf_front_model: sensor front end that delivers one sample per frame
// assumes the bench calls frame() and the block samples on the rising edge
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// front end: sample clock still outside frames
module amf_front_model (
  output var logic        o_sample_clk,
  output var logic [41:0] o_acc,
  output var logic [47:0] o_mag,
  output var logic [7:0]  o_temp
);
  // idle lines before the first frame
  initial begin
    o_sample_clk = 1'b0;
    o_acc = '0;
    o_mag = '0;
    o_temp = 8'h00;
  end

  // data set up half a period ahead of the edge, held half a period after
  task automatic frame(input logic [41:0] a, input logic [47:0] m,
                       input logic [7:0] t);
    #3;
    o_acc = a;
    o_mag = m;
    o_temp = t;
    #40 o_sample_clk = 1'b1;
    #40 o_sample_clk = 1'b0;
    // hold over: inverse shows up if the block captures late
    o_acc = ~a;
    o_mag = ~m;
    o_temp = ~t;
  endtask : frame
endmodule : amf_front_model
`default_nettype wire

// ==== amf_pkg.sv ====
// amf_pkg: constants for the accel output and sample queue readout block
// assumes one 8-bit register space reached by a serial register port
package amf_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] AMF_ADDR_STATUS = 8'h00; // sample_ready_status
  localparam logic [7:0] AMF_ADDR_X_HIGH = 8'h01; // accel_x_high
  localparam logic [7:0] AMF_ADDR_X_LOW  = 8'h02; // accel_x_low
  localparam logic [7:0] AMF_ADDR_Z_LOW  = 8'h06; // accel_z_low
  localparam logic [7:0] AMF_ADDR_SETUP  = 8'h09; // sample_queue_setup
  localparam logic [7:0] AMF_ADDR_TEMP   = 8'h51; // die_temperature
  // ==========================================================
  // field layout and reset values
  localparam int         AMF_MODE_MSB    = 7;
  localparam int         AMF_MODE_LSB    = 6;
  localparam int         AMF_WMRK_MSB    = 5;
  localparam int         AMF_READY_BIT   = 3;     // xyz ready in status
  localparam logic [7:0] AMF_SETUP_RST   = 8'h00;
  localparam logic [7:0] AMF_BYTE_RST    = 8'h00;
  localparam logic [1:0] AMF_MODE_OFF    = 2'h0;
  localparam logic [1:0] AMF_MODE_CIRC   = 2'h1;
  localparam logic [1:0] AMF_MODE_STOP   = 2'h2;
  localparam logic [1:0] AMF_MODE_TRIG   = 2'h3;
  localparam logic [1:0] AMF_MAG_OFF     = 2'h0;  // accelerometer only
  // ==========================================================
  // sizes and burst stream positions
  localparam int         AMF_DEPTH       = 32;
  localparam int         AMF_ACC_W       = 14;
  localparam int         AMF_MAG_W       = 16;
  localparam logic [3:0] AMF_POS_ACC_END = 4'h6;  // six accel bytes
  localparam logic [3:0] AMF_POS_HYB_END = 4'hc;  // twelve hybrid bytes
  localparam logic [3:0] AMF_POS_Z_HIGH  = 4'h4;
  localparam logic [3:0] AMF_POS_Z_LOW   = 4'h5;
endpackage : amf_pkg

// ==== amf_readout.sv ====
// amf_readout: accel output registers, 32-sample queue and burst readout
// assumes a serial engine on i_clk driving byte reads and writes, and a
// sensor front end whose sample clock and data come from another domain
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// generic synchronous queue with flush
module amf_fifo #(
  parameter int W  = 42,
  parameter int D  = 32,
  parameter int AW = $clog2(D)
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_flush,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data,
  output logic [AW:0]       o_count
);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // a pop frees a slot in the same cycle, so a full queue can still take
  assign o_out_valid = (cnt_r != '0);
  assign pop         = o_out_valid & i_out_ready;
  assign o_in_ready  = (cnt_r != (AW+1)'(D)) | pop;
  assign push        = i_in_valid & o_in_ready;
  assign o_out_data  = mem_r[rp_r];
  assign o_count     = cnt_r;

  // storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (i_flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : amf_fifo

// ============================================================
// top: register space, sample capture and queue control
module amf_readout #(
  parameter int DEPTH = amf_pkg::AMF_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_sample_clk,   // front-end sample strobe clock
  input  wire logic [13:0] i_x_sample,
  input  wire logic [13:0] i_y_sample,
  input  wire logic [13:0] i_z_sample,
  input  wire logic [15:0] i_mag_x,
  input  wire logic [15:0] i_mag_y,
  input  wire logic [15:0] i_mag_z,
  input  wire logic [7:0]  i_temp_raw,
  input  wire logic        i_active,       // 1 = active, 0 = standby
  input  wire logic        i_rate_change,  // auto sleep/wake pulse
  input  wire logic        i_fast_read,
  input  wire logic        i_hybrid,
  input  wire logic        i_hyb_autoinc,
  input  wire logic [1:0]  i_mag_mode,
  input  wire logic        i_trigger,      // queue trigger event pulse
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_rd_en,
  input  wire logic        i_rd_first,     // first byte of a burst
  input  wire logic        i_burst_end,
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_wr_data,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid,
  output logic [6:0]       o_fifo_count,
  output logic             o_fifo_ovf,
  output logic             o_fifo_wmrk,
  output logic             o_temp_valid
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = 3 * amf_pkg::AMF_ACC_W;

  logic [2:0]    clk_sync_r;              // [0] first stage only
  logic [SW-1:0] acc_meta_r;
  logic [SW-1:0] acc_sync_r;
  logic [47:0]   mag_meta_r;
  logic [47:0]   mag_sync_r;
  logic [7:0]    tmp_meta_r;
  logic [7:0]    tmp_sync_r;
  logic          new_sample;
  logic [SW-1:0] cur_r;
  logic [47:0]   mag_r;
  logic [7:0]    temp_r;
  logic [7:0]    setup_r;
  logic [1:0]    mode;
  logic [5:0]    wmrk;
  logic          ready_r;
  logic          active_r;
  logic          trig_r;
  logic          ovf_r;
  logic          flush;
  logic          q_in_valid;
  logic          q_out_valid;
  logic [SW-1:0] q_head;
  logic [AW:0]   q_count;
  logic          drop_old;
  logic          rd_pop;
  logic [6:0]    pre_lim;
  logic [7:0]    addr_r;
  logic          str_r;
  logic [3:0]    pos_r;
  logic          touched_r;
  logic [7:0]    addr;
  logic          in_str;
  logic [3:0]    pos;
  logic          direct;
  logic [7:0]    byte_sel;
  logic [7:0]    rd_data_r;
  logic          rd_valid_r;

  assign mode = setup_r[amf_pkg::AMF_MODE_MSB:amf_pkg::AMF_MODE_LSB];
  assign wmrk = setup_r[amf_pkg::AMF_WMRK_MSB:0];

  // ==========================================================
  // front-end crossing
  // data is held stable around the sample edge, so two flops per bit do
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_sync_r <= '0;
      acc_meta_r <= '0;
      acc_sync_r <= '0;
      mag_meta_r <= '0;
      mag_sync_r <= '0;
      tmp_meta_r <= '0;
      tmp_sync_r <= '0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], i_sample_clk};
      acc_meta_r <= {i_x_sample, i_y_sample, i_z_sample};
      acc_sync_r <= acc_meta_r;
      mag_meta_r <= {i_mag_x, i_mag_y, i_mag_z};
      mag_sync_r <= mag_meta_r;
      tmp_meta_r <= i_temp_raw;
      tmp_sync_r <= tmp_meta_r;
    end
  end

  // rising edge seen on synced stages only
  assign new_sample = clk_sync_r[1] & ~clk_sync_r[2];

  // current sample, magnetic and temperature copies
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_r  <= '0;
      mag_r  <= '0;
      temp_r <= amf_pkg::AMF_BYTE_RST;
    end else if (new_sample) begin
      cur_r  <= acc_sync_r;
      mag_r  <= mag_sync_r;
      temp_r <= tmp_sync_r;
    end
  end

  // data ready flag: a new sample wins over the clearing read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ready_r <= 1'b0;
    end else if (new_sample) begin
      ready_r <= 1'b1;
    end else if (i_rd_en && !in_str && addr == amf_pkg::AMF_ADDR_STATUS) begin
      ready_r <= 1'b0;
    end
  end

  // ==========================================================
  // setup register and queue control
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      setup_r <= amf_pkg::AMF_SETUP_RST;
    end else if (i_wr_en && i_reg_addr == amf_pkg::AMF_ADDR_SETUP) begin
      setup_r <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_r <= 1'b0;
    end else begin
      active_r <= i_active;
    end
  end

  // mode off holds the queue empty, which also zeroes the count
  assign flush = (mode == amf_pkg::AMF_MODE_OFF) | i_rate_change
               | (i_active & ~active_r);

  // trigger latch, cleared with the queue
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trig_r <= 1'b0;
    end else if (flush) begin
      trig_r <= 1'b0;
    end else if (i_trigger && mode == amf_pkg::AMF_MODE_TRIG) begin
      trig_r <= 1'b1;
    end
  end

  // pre-trigger depth; a zero watermark keeps the full depth
  assign pre_lim = (wmrk == '0) ? 7'(DEPTH) : {1'b0, wmrk};

  // oldest dropped to make room: circular, or trigger before the event
  always_comb begin
    drop_old = 1'b0;
    if (new_sample) begin
      unique case (mode)
        amf_pkg::AMF_MODE_CIRC:
          drop_old = (q_count == (AW+1)'(DEPTH));
        amf_pkg::AMF_MODE_TRIG:
          drop_old = !trig_r && (7'(q_count) >= pre_lim);
        default:
          drop_old = 1'b0;                           // stop mode drops new
      endcase
    end
  end

  // every edge outside mode off offers a sample; a full stop-mode queue refuses it
  assign q_in_valid = new_sample & (mode != amf_pkg::AMF_MODE_OFF);

  amf_fifo #(
    .W  (SW),
    .D  (DEPTH),
    .AW (AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_flush     (flush),
    .i_in_valid  (q_in_valid),
    .o_in_ready  (),
    .i_in_data   (acc_sync_r),
    .o_out_valid (q_out_valid),
    .i_out_ready (rd_pop | drop_old),
    .o_out_data  (q_head),
    .o_count     (q_count)
  );

  // overflow: set at full count wins over the clear by mode off
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovf_r <= 1'b0;
    end else if (q_count == (AW+1)'(DEPTH)) begin
      ovf_r <= 1'b1;
    end else if (mode == amf_pkg::AMF_MODE_OFF) begin
      ovf_r <= 1'b0;
    end
  end

  assign o_fifo_ovf   = ovf_r;
  assign o_fifo_count = 7'(q_count);
  // level flag; never stops acceptance
  assign o_fifo_wmrk  = (wmrk != '0)
                      && (7'(q_count) >= {1'b0, wmrk});
  assign o_temp_valid = (i_mag_mode != amf_pkg::AMF_MAG_OFF);

  // ==========================================================
  // burst address walk
  // bytes 1..6 form a stream cursor so fast read and hybrid can reorder
  assign direct = i_rd_first;
  assign addr   = direct ? i_reg_addr : addr_r;
  assign in_str = direct ? (i_reg_addr >= amf_pkg::AMF_ADDR_X_HIGH
                            && i_reg_addr <= amf_pkg::AMF_ADDR_Z_LOW)
                         : str_r;
  assign pos    = direct ? 4'(i_reg_addr - amf_pkg::AMF_ADDR_X_HIGH)
                         : pos_r;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_r <= '0;
      str_r  <= 1'b0;
      pos_r  <= '0;
    end else if (i_rd_en) begin
      if (in_str && !(direct && i_fast_read && pos[0])) begin
        // fast read steps two bytes, skipping the low halves
        if ((i_hybrid && i_hyb_autoinc
             && pos + (i_fast_read ? 4'h2 : 4'h1)
                < amf_pkg::AMF_POS_HYB_END)
            || pos + (i_fast_read ? 4'h2 : 4'h1)
               < amf_pkg::AMF_POS_ACC_END) begin
          str_r <= 1'b1;
          pos_r <= pos + (i_fast_read ? 4'h2 : 4'h1);
        end else begin
          str_r  <= 1'b0;
          addr_r <= amf_pkg::AMF_ADDR_Z_LOW + 8'h01;
        end
      end else if (!in_str && addr == amf_pkg::AMF_ADDR_STATUS) begin
        // status rolls straight into the output bytes
        str_r <= 1'b1;
        pos_r <= '0;
      end else begin
        str_r  <= 1'b0;
        addr_r <= addr + 8'h01;
      end
    end
  end

  // ==========================================================
  // read data selection
  function automatic logic [7:0] amf_acc_byte(input logic [SW-1:0] s,
                                              input logic [3:0]    p);
    logic [13:0] ax;
    ax = s[SW-1-14*(p>>1) -: 14];                     // x, y, z by pair
    // left justified: high = 13..6, low = 5..0 with two zero bits
    amf_acc_byte = p[0] ? {ax[5:0], 2'b00} : ax[13:6];
  endfunction : amf_acc_byte

  always_comb begin
    byte_sel = amf_pkg::AMF_BYTE_RST;
    if (in_str && pos < amf_pkg::AMF_POS_ACC_END) begin
      if (mode == amf_pkg::AMF_MODE_OFF) begin
        byte_sel = amf_acc_byte(cur_r, pos);
      end else if (direct && pos != '0) begin
        byte_sel = amf_pkg::AMF_BYTE_RST;
      end else if (q_out_valid) begin
        byte_sel = amf_acc_byte(q_head, pos);
      end
    end else if (in_str) begin
      byte_sel = pos[0] ? mag_r[47-8*(pos-6) -: 8]
                        : mag_r[47-8*(pos-6) -: 8];
    end else if (addr == amf_pkg::AMF_ADDR_STATUS) begin
      byte_sel = 8'(ready_r) << amf_pkg::AMF_READY_BIT;
    end else if (addr == amf_pkg::AMF_ADDR_SETUP) begin
      byte_sel = setup_r;
    end else if (addr == amf_pkg::AMF_ADDR_TEMP) begin
      byte_sel = temp_r;
    end
  end

  // ==========================================================
  // pop on reads of the queue head
  // the head is released once the last accel byte of the sample goes out,
  // or when the burst ends after X was read: the rest of it is lost
  assign rd_pop = q_out_valid && mode != amf_pkg::AMF_MODE_OFF
                && ((i_rd_en && in_str && !(direct && pos != '0)
                     && pos == (i_fast_read ? amf_pkg::AMF_POS_Z_HIGH
                                            : amf_pkg::AMF_POS_Z_LOW))
                    || (i_burst_end && touched_r));

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      touched_r <= 1'b0;
    end else if (rd_pop || flush) begin
      touched_r <= 1'b0;
    end else if (i_rd_en && in_str && pos == '0 && q_out_valid) begin
      touched_r <= 1'b1;
    end
  end

  // registered answer one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_data_r  <= amf_pkg::AMF_BYTE_RST;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= i_rd_en;
      if (i_rd_en) begin
        rd_data_r <= byte_sel;
      end
    end
  end

  assign o_rd_data  = rd_data_r;
  assign o_rd_valid = rd_valid_r;
endmodule : amf_readout

`default_nettype wire

// ==== amf_readout_asserts.sv ====
// amf_readout_asserts: port-level checks on the readout block
// assumes it is bound into amf_readout and sees only its ports
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// checker
module amf_readout_asserts #(
  parameter int DEPTH = amf_pkg::AMF_DEPTH
) (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_active,
  input wire logic       i_rate_change,
  input wire logic [1:0] i_mag_mode,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_rd_en,
  input wire logic       i_rd_first,
  input wire logic       i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic [6:0] o_fifo_count,
  input wire logic       o_fifo_ovf,
  input wire logic       o_fifo_wmrk,
  input wire logic       o_temp_valid
);
  // shadow of the setup byte, kept from port writes
  logic [7:0] setup_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) setup_r <= amf_pkg::AMF_SETUP_RST;
    else if (i_wr_en && i_reg_addr == amf_pkg::AMF_ADDR_SETUP)
      setup_r <= i_wr_data;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_off_wr;
    i_wr_en && i_reg_addr == amf_pkg::AMF_ADDR_SETUP &&
      i_wr_data[7:6] == amf_pkg::AMF_MODE_OFF;
  endsequence
  sequence s_cleared;
    o_fifo_count == 7'h00 && !o_fifo_ovf && !o_fifo_wmrk;
  endsequence

  // trigger mode reuses the watermark, so the flag check skips it
  a_off_clears: assert property (s_off_wr |-> ##2 s_cleared)
    else $error("queue flags not cleared after disable");
  a_rd_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read byte not answered next cycle");
  a_rd_quiet: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read valid without a read");
  a_direct_zero: assert property (i_rd_en && i_rd_first &&
    i_reg_addr >= 8'h02 && i_reg_addr <= amf_pkg::AMF_ADDR_Z_LOW &&
    setup_r[7:6] != 2'h0 |=> o_rd_data == 8'h00)
    else $error("direct output read not zero with queue on");
  a_ovf_full: assert property (o_fifo_count == DEPTH |->
    ##[0:1] o_fifo_ovf)
    else $error("overflow flag missing at full count");
  a_count_max: assert property (o_fifo_count <= DEPTH)
    else $error("count above depth");
  a_wmrk_level: assert property (setup_r[7:6] != 2'h3 |->
    o_fifo_wmrk == (setup_r[5:0] != 6'h00 &&
    o_fifo_count >= {1'b0, setup_r[5:0]}))
    else $error("watermark flag disagrees with count");
  a_temp_valid: assert property (o_temp_valid ==
    (i_mag_mode != amf_pkg::AMF_MAG_OFF))
    else $error("temperature valid wrong");
  a_active_flush: assert property ($rose(i_active) |->
    ##[1:2] o_fifo_count == 7'h00)
    else $error("queue not flushed on wake");
  a_rate_flush: assert property (i_rate_change |->
    ##[1:2] o_fifo_count == 7'h00)
    else $error("queue not flushed on rate change");
  a_count_step: assert property (o_fifo_count == $past(o_fifo_count) ||
    o_fifo_count == 7'h00 || o_fifo_count == $past(o_fifo_count) + 7'h01 ||
    o_fifo_count + 7'h01 == $past(o_fifo_count))
    else $error("count moved by more than one");
endmodule : amf_readout_asserts

bind amf_readout amf_readout_asserts #(.DEPTH(DEPTH)) amf_readout_asserts_i (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_active(i_active),
  .i_rate_change(i_rate_change), .i_mag_mode(i_mag_mode),
  .i_reg_addr(i_reg_addr), .i_rd_en(i_rd_en), .i_rd_first(i_rd_first),
  .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .o_fifo_count(o_fifo_count),
  .o_fifo_ovf(o_fifo_ovf), .o_fifo_wmrk(o_fifo_wmrk),
  .o_temp_valid(o_temp_valid));
`default_nettype wire

// ==== amf_readout_tb.sv ====
// amf_readout_tb: self-checking bench, host side plus queue model
// assumes amf_front_model drives the sample link
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench
module amf_readout_tb;
  localparam int DEPTH = 8; // short queue keeps fill runs brief
  logic        i_clk, i_reset_n, active, rate_chg, fast, hyb, hyb_ai, trig;
  logic        rd_en, rd_first, burst_end, wr_en, trig_seen, ovf_m;
  logic        sclk, rd_valid, ovf, wmrk, tvalid;
  logic [1:0]  mag_mode, mode;
  logic [5:0]  wm;
  logic [6:0]  cnt;
  logic [7:0]  addr, wdata, rd_data, tmp, cur_t;
  logic [15:0] rnd;
  logic [41:0] acc, cur_a;
  logic [47:0] mag, cur_m;
  logic [41:0] q[$];
  logic [7:0]  exp_q[$], got_q[$];
  int          bad_count, num_checks, md;

  amf_front_model amf_front_model_i (.o_sample_clk(sclk), .o_acc(acc),
    .o_mag(mag), .o_temp(tmp));
  amf_readout #(.DEPTH(DEPTH)) amf_readout_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sample_clk(sclk),
    .i_x_sample(acc[41:28]), .i_y_sample(acc[27:14]),
    .i_z_sample(acc[13:0]), .i_mag_x(mag[47:32]), .i_mag_y(mag[31:16]),
    .i_mag_z(mag[15:0]), .i_temp_raw(tmp), .i_active(active),
    .i_rate_change(rate_chg), .i_fast_read(fast), .i_hybrid(hyb),
    .i_hyb_autoinc(hyb_ai), .i_mag_mode(mag_mode), .i_trigger(trig),
    .i_reg_addr(addr), .i_rd_en(rd_en), .i_rd_first(rd_first),
    .i_burst_end(burst_end), .i_wr_en(wr_en), .i_wr_data(wdata),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_fifo_count(cnt),
    .o_fifo_ovf(ovf), .o_fifo_wmrk(wmrk), .o_temp_valid(tvalid));

  // clock, read monitor and watchdog
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (rd_valid === 1'b1) got_q.push_back(rd_data);
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  // flags and count against the model; wait for the edge's updates
  task automatic chk_stat();
    logic [7:0] e;
    logic [7:0] g;
    #1;
    e = {ovf_m, (wm != 0) && (q.size() >= wm), 6'(q.size())};
    g = {ovf, wmrk, cnt[5:0]};
    if (mode == amf_pkg::AMF_MODE_TRIG) {e[6], g[6]} = 2'b00;
    chk_byte("status", e, g);
  endtask : chk_stat

  // byte order of one sample, high byte first for each axis
  task automatic exp_add(input logic [41:0] a, input logic [47:0] m,
                         input logic f, input logic h);
    logic [13:0] v;
    logic [15:0] w;
    for (int k = 0; k < 3; k++) begin
      v = a[41-14*k -: 14];
      exp_q.push_back(v[13:6]);
      if (!f) exp_q.push_back({v[5:0], 2'b00});
    end
    for (int k = 0; h && k < 3; k++) begin
      w = m[47-16*k -: 16];
      exp_q.push_back(w[15:8]);
      if (!f) exp_q.push_back(w[7:0]);
    end
  endtask : exp_add

  // back-to-back byte reads, then the burst is closed
  task automatic burst(input logic [7:0] a, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      rd_en <= 1'b1;
      rd_first <= (k == 0);
      addr <= a;
    end
    @(posedge i_clk);
    rd_en <= 1'b0;
    rd_first <= 1'b0;
    burst_end <= 1'b1;
    @(posedge i_clk);
    burst_end <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : burst

  task automatic drain();
    while (exp_q.size() > 0)
      chk_byte("rd_data", exp_q.pop_front(),
               got_q.size() > 0 ? got_q.pop_front() : 8'hxx);
    chk_byte("extra_bytes", 8'h00, 8'(got_q.size()));
    got_q.delete();
  endtask : drain

  task automatic smp();
    logic [111:0] v;
    for (int k = 0; k < 7; k++) begin
      rnd = lfsr(rnd);
      v = {v[95:0], rnd};
    end
    amf_front_model_i.frame(v[111:70], v[69:22], v[7:0]);
    repeat (2) @(posedge i_clk);
    cur_t = v[7:0];
    if (mode == amf_pkg::AMF_MODE_OFF) begin
      cur_a = v[111:70];
      cur_m = v[69:22];
    end else begin
      if (mode == 2'h1 && q.size() == DEPTH) q.delete(0);
      if (mode == 2'h3 && !trig_seen && q.size() >= (wm == 0 ? DEPTH : wm))
        q.delete(0);
      if (q.size() < DEPTH) q.push_back(v[111:70]);
      if (q.size() == DEPTH) ovf_m = 1'b1;
    end
  endtask : smp

  task automatic fill(input int n);
    for (int k = 0; k < n; k++) begin
      smp();
      chk_stat();
    end
  endtask : fill

  task automatic pop_all();
    while (q.size() > 0) begin
      rnd = lfsr(rnd);
      fast <= rnd[0]; // fast read pops at z high
      exp_add(q[0], 48'h0, rnd[0], 1'b0);
      q.delete(0);
      burst(amf_pkg::AMF_ADDR_X_HIGH, rnd[0] ? 3 : 6);
      drain();
      chk_stat();
    end
  endtask : pop_all

  // setup writes go through standby; modes change only via disabled
  task automatic wr(input logic [7:0] d);
    @(posedge i_clk);
    active <= 1'b0;
    @(posedge i_clk);
    wr_en <= 1'b1;
    addr <= amf_pkg::AMF_ADDR_SETUP;
    wdata <= d;
    @(posedge i_clk);
    wr_en <= 1'b0;
    active <= 1'b1;
    repeat (3) @(posedge i_clk);
    {mode, wm} = d;
    trig_seen = 1'b0;
    q.delete();
    if (d[7:6] == amf_pkg::AMF_MODE_OFF) ovf_m = 1'b0;
    chk_stat();
  endtask : wr

  initial begin
    {rate_chg, fast, hyb, hyb_ai, trig, rd_en, rd_first} = '0;
    {burst_end, wr_en, trig_seen, ovf_m, mag_mode, mode, wm} = '0;
    {addr, wdata, bad_count, num_checks} = '0;
    active = 1'b1;
    i_reset_n = 1'b0;
    rnd = 16'he6b2;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    smp();
    exp_q.push_back(cur_t);
    burst(amf_pkg::AMF_ADDR_TEMP, 1);
    drain();
    exp_q.push_back(8'h00);
    burst(8'h30, 1);
    drain();
    chk_byte("temp_valid", 8'h00, {7'h00, tvalid});
    mag_mode <= rnd[1:0] | 2'h1;
    @(posedge i_clk);
    #1 chk_byte("temp_valid", 8'h01, {7'h00, tvalid});
    exp_add(cur_a, cur_m, 1'b0, 1'b0);
    burst(amf_pkg::AMF_ADDR_X_HIGH, 6);
    drain();
    fast <= 1'b1;
    exp_add(cur_a, cur_m, 1'b1, 1'b0);
    burst(amf_pkg::AMF_ADDR_X_HIGH, 3);
    drain();
    exp_q.push_back({cur_a[33:28], 2'b00});
    burst(amf_pkg::AMF_ADDR_X_LOW, 1);
    drain();
    {fast, hyb, hyb_ai} <= 3'b011;
    exp_add(cur_a, cur_m, 1'b0, 1'b1);
    burst(amf_pkg::AMF_ADDR_X_HIGH, 12);
    drain();
    hyb <= 1'b0;
    hyb_ai <= rnd[2];
    // status byte leads the six output bytes, then reads clear
    exp_q.push_back(8'h01 << amf_pkg::AMF_READY_BIT);
    exp_add(cur_a, cur_m, 1'b0, 1'b0);
    burst(amf_pkg::AMF_ADDR_STATUS, 7);
    drain();
    exp_q.push_back(8'h00);
    burst(amf_pkg::AMF_ADDR_STATUS, 1);
    drain();
    // circular then stop-when-full, each overfilled and drained
    for (md = 1; md <= 2; md++) begin
      wr({md[1:0], 6'h03});
      fill(DEPTH + 2);
      exp_q.push_back(8'h00);
      burst(amf_pkg::AMF_ADDR_X_LOW, 1);
      drain();
      exp_q.push_back(q[0][41:34]);
      q.delete(0);
      burst(amf_pkg::AMF_ADDR_X_HIGH, 1);
      drain();
      chk_stat();
      pop_all();
      wr(8'h00);
    end
    wr({2'h3, 6'h02});
    fill(4);
    @(posedge i_clk);
    trig <= 1'b1;
    @(posedge i_clk);
    trig <= 1'b0;
    trig_seen = 1'b1;
    fill(DEPTH + 1);
    pop_all();
    wr(8'h00);
    wr(8'h40);
    fill(2);
    @(posedge i_clk);
    rate_chg <= 1'b1;
    @(posedge i_clk);
    rate_chg <= 1'b0;
    q.delete();
    repeat (3) @(posedge i_clk);
    chk_stat();
    fill(2);
    wr(8'h40);
    wr(8'h00);
    tally_and_finish();
  end
endmodule : amf_readout_tb
`default_nettype wire
